/* File: verilog/lwc_regs.vh */
// register map, field layout and encodings of the link width control block
`ifndef LWC_REGS_VH
`define LWC_REGS_VH
// byte offsets of the control word of each link, function 0 and function 4 copy
`define LWC_OFF_LINK0 8'h84
`define LWC_OFF_LINK1 8'hA4
`define LWC_OFF_LINK2 8'hC4
`define LWC_OFF_LINK3 8'hE4
// function select bit in the avalon word address space (function 4 copy)
`define LWC_FN4_BIT 8
// field positions
`define LWC_OUT_HI 30
`define LWC_OUT_LO 28
`define LWC_IN_HI 26
`define LWC_IN_LO 24
`define LWC_MAX_HI 22
`define LWC_MAX_LO 20
// width encodings
`define LWC_W16 3'h1
`define LWC_W8 3'h0
`define LWC_WNC 3'h7
// status word of own choosing: active outgoing widths per copy
`define LWC_OFF_STATUS 8'hFC
`define LWC_RD_ZERO 32'h0000_0000
`endif

/* File: verilog/lwc_field.v */
// one staged width field with write gating
`timescale 1ns/1ns
`include "lwc_regs.vh"
module lwc_field (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // cold reset seed and controls
    input wire cold_load,
    input wire [2:0] seed,
    input wire wr_en,
    input wire [2:0] wr_val,
    input wire lock,
    input wire ganged,
    input wire regroup,
    input wire apply,
    // values
    output reg [2:0] prog_ff,
    output reg [2:0] act_ff
);

// legality and gating of a software write
wire legal = (wr_val == `LWC_W16) || (wr_val == `LWC_W8) || (wr_val == `LWC_WNC);
// RL4: refuse regroup 16
wire no16 = regroup && !ganged && (wr_val == `LWC_W16);
wire [2:0] nxt_prog = cold_load ? seed :
                      (wr_en && legal && !lock && !no16) ? wr_val : prog_ff;

// programmed value and active width
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        prog_ff <= `LWC_WNC;
        act_ff <= `LWC_WNC;
    end else begin
        prog_ff <= nxt_prog;
        // RL6: staged until apply
        if (cold_load)
            act_ff <= seed;
        else if (apply)
            act_ff <= prog_ff;
    end
end

endmodule // lwc_field

/* File: verilog/lwc_top.v */
// link width control register bank with avalon-mm slave
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ns
`include "lwc_regs.vh"

// Functional notes
// RL1: outgoing width bits 30:28 encode 16 as 001, 8 as 000, none as 111.
// RL2: incoming width bits 26:24 read-write with the same encoding.
// RL3: cold reset value of each width comes from negotiated partner widths.
// RL4: while regrouping, 16-bit writes refused unless the link is already ganged.
// RL5: link found disconnected at cold reset locks both width fields.
// RL6: written width takes effect only at warm reset or stop-pin disconnect.
// RL7: max outgoing width bits 22:20 read-only, 8 or 16 by processor version.
// RL8: unganged link reports an 8-bit maximum outgoing width.
// RL9: function 0 copy is whole link or sublink 0; function 4 is sublink 1.
// RL10: offset ranges 80-98, A0-B8, C0-D8, E0-F8 map to links 0 to 3; only offsets 84, A4, C4 and E4 are decoded, besides the status word at FC.
// RL11: registers of unsupported links read as reserved.
// RL12: reserved bits 31, 27, 23 and 19 read zero and ignore writes.
module lwc_top (
    // clock and resets
    input wire clk_sys,
    input wire rst_n,
    input wire cold_rst_done,
    input wire warm_rst,
    // link side
    input wire link_stop_pin,
    input wire [3:0] link_present,
    input wire [3:0] link_ganged,
    input wire [3:0] link_regroup,
    input wire [3:0] link_disc,
    input wire [3:0] partner16,
    input wire ver16,
    // avalon-mm slave
    input wire [8:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // active widths, eight copies of out and in
    output reg [23:0] act_out_ff,
    output reg [23:0] act_in_ff
);

//------------------------------------------------------------
// pin synchronisers
//------------------------------------------------------------
reg [2:0] stop_sync_ff;
reg [2:0] warm_sync_ff;
reg [2:0] cold_sync_ff;
reg stop_state_ff;
reg warm_state_ff;
reg cold_state_ff;
reg cold_done_ff;

// three stage sync, change counted when stages two and three agree
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        stop_sync_ff <= 3'h7;
        warm_sync_ff <= 3'h0;
        cold_sync_ff <= 3'h0;
        stop_state_ff <= 1'b1;
        warm_state_ff <= 1'b0;
        cold_state_ff <= 1'b0;
        cold_done_ff <= 1'b0;
    end else begin
        stop_sync_ff <= {stop_sync_ff[1:0], link_stop_pin};
        warm_sync_ff <= {warm_sync_ff[1:0], warm_rst};
        cold_sync_ff <= {cold_sync_ff[1:0], cold_rst_done};
        if (stop_sync_ff[1] == stop_sync_ff[2])
            stop_state_ff <= stop_sync_ff[2];
        if (warm_sync_ff[1] == warm_sync_ff[2])
            warm_state_ff <= warm_sync_ff[2];
        if (cold_sync_ff[1] == cold_sync_ff[2])
            cold_state_ff <= cold_sync_ff[2];
        cold_done_ff <= cold_state_ff;
    end
end

// one-cycle events derived from the filtered levels
wire cold_load = cold_state_ff && !cold_done_ff;
wire stop_rise = (stop_sync_ff[2] == stop_sync_ff[1]) && stop_sync_ff[2] && !stop_state_ff;
wire warm_fall = (warm_sync_ff[2] == warm_sync_ff[1]) && !warm_sync_ff[2] && warm_state_ff;
// RL6: warm reset end or disconnect sequence end
wire apply = stop_rise || warm_fall;

//------------------------------------------------------------
// address decode
//------------------------------------------------------------
wire [7:0] byte_off = {avs_address[5:0], 2'b00};
wire fn4 = avs_address[`LWC_FN4_BIT];
wire hit_status = (avs_address[7:0] == (`LWC_OFF_STATUS >> 2)) && !fn4;
reg [1:0] sel_link;
reg sel_hit;

// RL10: offset to link mapping
always @* begin
    sel_link = 2'h0;
    sel_hit = 1'b0;
    if (avs_address[7:6] == 2'h0) begin
        case (byte_off)
            `LWC_OFF_LINK0: begin
                sel_link = 2'h0;
                sel_hit = 1'b1;
            end
            `LWC_OFF_LINK1: begin
                sel_link = 2'h1;
                sel_hit = 1'b1;
            end
            `LWC_OFF_LINK2: begin
                sel_link = 2'h2;
                sel_hit = 1'b1;
            end
            `LWC_OFF_LINK3: begin
                sel_link = 2'h3;
                sel_hit = 1'b1;
            end
            default: begin
                sel_hit = 1'b0;
            end
        endcase
    end
end

// RL9: copy index, function 4 is sublink 1
wire [2:0] sel_copy = {fn4, sel_link};
// RL11: unsupported links are reserved
wire reg_hit = sel_hit && link_present[sel_link] && !(fn4 && link_ganged[sel_link]);
// high in the cycle in which waitrequest stands low
reg busy_ff;
// byte lane 3 carries both width fields; the write lands only where waitrequest is low
wire wr_ok = avs_write && busy_ff && reg_hit && avs_byteenable[3];

//------------------------------------------------------------
// width fields, one pair per copy
//------------------------------------------------------------
wire [23:0] prog_out;
wire [23:0] prog_in;
wire [23:0] act_out;
wire [23:0] act_in;

genvar gi;
generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_copy
        // RL3: seed from partner widths
        wire [2:0] seed = !link_present[gi % 4] || link_disc[gi % 4] ? `LWC_WNC :
            ((gi < 4) && link_ganged[gi % 4] && partner16[gi % 4] && ver16) ?
            `LWC_W16 : `LWC_W8;
        wire we = wr_ok && (sel_copy == gi);
        // RL5: disconnected links lock
        wire lock = link_disc[gi % 4];
        // RL1: outgoing width field
        lwc_field u_out (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .cold_load(cold_load),
            .seed(seed),
            .wr_en(we),
            .wr_val(avs_writedata[`LWC_OUT_HI:`LWC_OUT_LO]),
            .lock(lock),
            .ganged(link_ganged[gi % 4]),
            .regroup(link_regroup[gi % 4]),
            .apply(apply),
            .prog_ff(prog_out[3 * gi + 2:3 * gi]),
            .act_ff(act_out[3 * gi + 2:3 * gi])
        );
        // RL2: incoming width field
        lwc_field u_in (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .cold_load(cold_load),
            .seed(seed),
            .wr_en(we),
            .wr_val(avs_writedata[`LWC_IN_HI:`LWC_IN_LO]),
            .lock(lock),
            .ganged(link_ganged[gi % 4]),
            .regroup(link_regroup[gi % 4]),
            .apply(apply),
            .prog_ff(prog_in[3 * gi + 2:3 * gi]),
            .act_ff(act_in[3 * gi + 2:3 * gi])
        );
    end
endgenerate

//------------------------------------------------------------
// read mux
//------------------------------------------------------------
reg [31:0] rd_val;
reg [2:0] max_out;

// RL7: max width by version
// RL8: unganged reports 8 bits
// RL12: reserved bits read zero
always @* begin
    max_out = (ver16 && link_ganged[sel_link]) ? `LWC_W16 : `LWC_W8;
    rd_val = `LWC_RD_ZERO;
    if (reg_hit) begin
        rd_val[`LWC_OUT_HI:`LWC_OUT_LO] = prog_out[3 * sel_copy +: 3];
        rd_val[`LWC_IN_HI:`LWC_IN_LO] = prog_in[3 * sel_copy +: 3];
        rd_val[`LWC_MAX_HI:`LWC_MAX_LO] = max_out;
    end else if (hit_status) begin
        rd_val[23:0] = act_out;
    end
end

//------------------------------------------------------------
// bus handshake: one wait cycle for every request
//------------------------------------------------------------
// waitrequest high in the request cycle, low in the next
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        busy_ff <= 1'b0;
        avs_waitrequest <= 1'b1;
        avs_readdata <= `LWC_RD_ZERO;
    end else begin
        busy_ff <= (avs_read || avs_write) && !busy_ff;
        avs_waitrequest <= !((avs_read || avs_write) && !busy_ff);
        if (avs_read && !busy_ff)
            avs_readdata <= rd_val;
    end
end

// registered copies of the active widths
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        act_out_ff <= {8{`LWC_WNC}};
        act_in_ff <= {8{`LWC_WNC}};
    end else begin
        act_out_ff <= act_out;
        act_in_ff <= act_in;
    end
end

endmodule // lwc_top

/* File: test/lwc_peer.sv */
// connected link device model: negotiated widths and cold handshake
`timescale 1ns/1ns
module lwc_peer (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // negotiation results
    output logic cold_rst_done,
    output logic [3:0] partner16,
    output logic [3:0] link_disc
);
    logic [2:0] cnt_ff;
    assign partner16 = 4'hF;
    assign link_disc = 4'h4;
    // negotiation ends a few cycles after reset
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            cnt_ff <= 3'h0;
        else if (cnt_ff != 3'h4)
            cnt_ff <= cnt_ff + 3'h1;
    end
    assign cold_rst_done = (cnt_ff == 3'h4);
endmodule // lwc_peer

/* File: test/lwc_checker.sv */
// protocol and width field checks for the link width bank
`timescale 1ns/1ns
module lwc_checker (
    // clock and resets
    input wire clk_sys,
    input wire rst_n,
    input wire cold_rst_done,
    input wire warm_rst,
    // link side
    input wire link_stop_pin,
    input wire [3:0] link_ganged,
    input wire [3:0] link_regroup,
    input wire [3:0] link_disc,
    // bus
    input wire [8:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // widths
    input wire [23:0] act_out_ff,
    input wire [23:0] act_in_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [2:0] prev_ff;
    logic [3:0] quiet_ff;
    // cycles since the last change of the cold-done, warm reset or stop pin
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev_ff <= 3'h0;
            quiet_ff <= 4'h0;
        end else begin
            prev_ff <= {cold_rst_done, warm_rst, link_stop_pin};
            if (prev_ff != {cold_rst_done, warm_rst, link_stop_pin})
                quiet_ff <= 4'h0;
            else if (quiet_ff != 4'hF)
                quiet_ff <= quiet_ff + 4'h1;
        end
    end
    wait_stand_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low too long");
    answer_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("no answer after request");
    idle_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("answer without request");
    rsvd_zero_a: assert property (!avs_waitrequest && $past(avs_read)
        |-> !avs_readdata[31] && !avs_readdata[27]) else $error("reserved bit set");
    max_narrow_a: assert property (!avs_waitrequest && $past(avs_read)
        && $past(avs_address) == 9'h029 && !link_ganged[1] |-> avs_readdata[22:20] == 3'h0)
        else $error("unganged max not 8");
    hold_a: assert property ($changed({act_out_ff, act_in_ff}) |-> quiet_ff < 4'hC)
        else $error("width changed without apply");
    lock_a: assert property (link_disc[2]
        |-> act_out_ff[8:6] == 3'h7 && act_in_ff[8:6] == 3'h7) else $error("locked width moved");
    regroup_a: assert property (link_regroup[1] && !link_ganged[1]
        |-> act_out_ff[5:3] != 3'h1) else $error("16 bit while regrouping");
endmodule // lwc_checker
bind lwc_top lwc_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .cold_rst_done(cold_rst_done), .warm_rst(warm_rst), .link_stop_pin(link_stop_pin),
    .link_ganged(link_ganged), .link_regroup(link_regroup), .link_disc(link_disc),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .act_out_ff(act_out_ff), .act_in_ff(act_in_ff));

/* File: test/tb_top.sv */
// self-checking bench for the link width bank
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_fail++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic warm_rst = 1'b0;
    logic link_stop_pin = 1'b1;
    logic ver16 = 1'b1;
    logic [3:0] link_regroup = 4'h2;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [8:0] avs_address = 9'h000;
    logic [31:0] avs_writedata = 32'h0;
    logic cold_rst_done, avs_waitrequest;
    logic [3:0] partner16, link_disc;
    logic [31:0] avs_readdata, rd;
    logic [23:0] act_out_ff, act_in_ff;
    int n_fail = 0;
    int n_compared = 0;
    always #20 clk_sys = ~clk_sys;
    lwc_peer u_peer (.clk_sys(clk_sys), .rst_n(rst_n), .cold_rst_done(cold_rst_done),
        .partner16(partner16), .link_disc(link_disc));
    lwc_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .cold_rst_done(cold_rst_done),
        .warm_rst(warm_rst), .link_stop_pin(link_stop_pin), .link_present(4'h7),
        .link_ganged(4'h1), .link_regroup(link_regroup), .link_disc(link_disc),
        .partner16(partner16), .ver16(ver16), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .act_out_ff(act_out_ff), .act_in_ff(act_in_ff));
    task automatic complete_run;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // one bus access, held until waitrequest is seen low
    task automatic xfer(input logic wr, input logic [8:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // request stands until waitrequest is sampled low at a rising edge
        do
            @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic ck(input logic [8:0] a, input logic [2:0] o, input logic [2:0] i);
        xfer(1'b0, a, 32'h0);
        `CHK("out width", o, rd[30:28])
        `CHK("in width", i, rd[26:24])
        `CHK("reserved", 4'h0, {rd[31], rd[27], rd[23], rd[19]})
    endtask
    task automatic t_seed;
        ck(9'h021, 3'h1, 3'h1);
        `CHK("max ganged", 3'h1, rd[22:20])
        ck(9'h029, 3'h0, 3'h0);
        `CHK("max unganged", 3'h0, rd[22:20])
        ck(9'h031, 3'h7, 3'h7);
        xfer(1'b0, 9'h039, 32'h0);
        `CHK("absent link", 32'h0, rd)
        ck(9'h129, 3'h0, 3'h0);
        ver16 <= 1'b0;
        xfer(1'b0, 9'h021, 32'h0);
        `CHK("max version 8", 3'h0, rd[22:20])
        ver16 <= 1'b1;
        xfer(1'b0, 9'h121, 32'h0);
        `CHK("fn4 of ganged", 32'h0, rd)
        $display("test seed done");
    endtask
    task automatic t_stage;
        xfer(1'b1, 9'h021, 32'h8888_0000);
        ck(9'h021, 3'h0, 3'h0);
        `CHK("before apply", 3'h1, act_out_ff[2:0])
        link_stop_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        link_stop_pin <= 1'b1;
        repeat (12) @(posedge clk_sys);
        `CHK("after stop", 3'h0, act_in_ff[2:0])
        xfer(1'b1, 9'h021, 32'h1100_0000);
        `CHK("staged", 3'h0, act_out_ff[2:0])
        warm_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        warm_rst <= 1'b0;
        repeat (12) @(posedge clk_sys);
        `CHK("after warm", 3'h1, act_out_ff[2:0])
        $display("test stage done");
    endtask
    task automatic t_refuse;
        xfer(1'b1, 9'h029, 32'h1100_0000);
        ck(9'h029, 3'h0, 3'h0);
        xfer(1'b1, 9'h021, 32'h2200_0000);
        ck(9'h021, 3'h1, 3'h1);
        link_regroup <= 4'h3;
        xfer(1'b1, 9'h021, 32'h0);
        ck(9'h021, 3'h0, 3'h0);
        xfer(1'b1, 9'h021, 32'h1100_0000);
        ck(9'h021, 3'h1, 3'h1);
        link_regroup <= 4'h2;
        xfer(1'b1, 9'h031, 32'h0);
        ck(9'h031, 3'h7, 3'h7);
        xfer(1'b1, 9'h129, 32'h7700_0000);
        ck(9'h129, 3'h7, 3'h7);
        ck(9'h029, 3'h0, 3'h0);
        $display("test refuse done");
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (12) @(posedge clk_sys);
        t_seed();
        t_stage();
        t_refuse();
        complete_run();
    end
    // watchdog
    initial begin
        #200000;
        n_fail++;
        complete_run();
    end
endmodule // tb_top
